// ==== hdl/nac_pkg.sv ====
package nac_pkg;
  typedef enum logic [2:0] {
    NAC_IDLE = 3'b001,
    NAC_PROG = 3'b010,
    NAC_READ = 3'b100
  } nac_state_e;
  typedef struct packed {
    logic [1:0] space;
    logic erase;
    logic write;
    logic read;
  } nac_cmd_s;
  typedef logic [2:0] nac_irq_t;
endpackage

// ==== hdl/nac_regs.svh ====
`ifndef NAC_REGS_SVH
`define NAC_REGS_SVH
`define NAC_OFS_CTRL 12'hfa6
`define NAC_OFS_IRQ_STAT 12'hfb0
`define NAC_OFS_IRQ_MASK 12'hfb4
`define NAC_BIT_PGM 7
`define NAC_BIT_CFG 6
`define NAC_BIT_FREE 4
`define NAC_BIT_ERR 3
`define NAC_BIT_WRITE_GATE 2
`define NAC_BIT_WR 1
`define NAC_BIT_RD 0
`define NAC_CTRL_RST 8'h00
`define NAC_IRQ_WDONE 0
`define NAC_IRQ_RDONE 1
`define NAC_IRQ_ERR 2
`define NAC_PROG_CYCLES 16'h0100
`endif

// ==== hdl/nac_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module nac_timer #(
  parameter logic [15:0] CYCLES = 16'h0100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [15:0] cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt_reg <= CYCLES;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_reg == 16'h0001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/nac_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nac_regs.svh"
module nac_top #(
  parameter logic [15:0] PROG_CYCLES = `NAC_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prog_reset,
  output nac_pkg::nac_cmd_s nvm_cmd,
  output logic irq
);
  import nac_pkg::*;

  logic [7:0] ctrl_reg;
  nac_irq_t stat_reg;
  nac_irq_t mask_reg;
  nac_state_e state_reg;
  logic timer_busy;
  logic timer_done;
  logic timer_start;
  logic wr_acc;
  logic rd_acc;
  logic set_wr;
  logic set_rd;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign set_wr = wr_acc && hit(paddr, `NAC_OFS_CTRL) && pwdata[`NAC_BIT_WR]
                  && ctrl_reg[`NAC_BIT_WRITE_GATE] && state_reg == NAC_IDLE
                  && !timer_busy;
  assign set_rd = wr_acc && hit(paddr, `NAC_OFS_CTRL) && pwdata[`NAC_BIT_RD]
                  && !pwdata[`NAC_BIT_PGM] && state_reg == NAC_IDLE;
  assign timer_start = state_reg == NAC_PROG && !timer_busy && !timer_done;

  nac_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(timer_start),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= NAC_IDLE;
    end else begin
      unique case (state_reg)
        NAC_IDLE: begin
          if (set_wr) begin
            state_reg <= NAC_PROG;
          end else if (set_rd) begin
            state_reg <= NAC_READ;
          end
        end
        NAC_PROG: begin
          if (prog_reset || timer_done) begin
            state_reg <= NAC_IDLE;
          end
        end
        NAC_READ: begin
          state_reg <= NAC_IDLE;
        end
      endcase
    end
  end

  // Control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `NAC_CTRL_RST;
    end else begin
      if (wr_acc && hit(paddr, `NAC_OFS_CTRL) && state_reg == NAC_IDLE) begin
        ctrl_reg[`NAC_BIT_PGM] <= pwdata[`NAC_BIT_PGM];
        ctrl_reg[`NAC_BIT_CFG] <= pwdata[`NAC_BIT_CFG];
        ctrl_reg[`NAC_BIT_FREE] <= pwdata[`NAC_BIT_FREE];
        ctrl_reg[`NAC_BIT_WRITE_GATE] <= pwdata[`NAC_BIT_WRITE_GATE];
        ctrl_reg[`NAC_BIT_ERR] <= pwdata[`NAC_BIT_ERR];
      end else if (wr_acc && hit(paddr, `NAC_OFS_CTRL)) begin
        ctrl_reg[`NAC_BIT_WRITE_GATE] <= pwdata[`NAC_BIT_WRITE_GATE];
      end
      if (set_wr) begin
        ctrl_reg[`NAC_BIT_WR] <= 1'b1;
      end
      if (set_rd) begin
        ctrl_reg[`NAC_BIT_RD] <= 1'b1;
      end
      if (state_reg == NAC_READ) begin
        ctrl_reg[`NAC_BIT_RD] <= 1'b0;
      end
      if (state_reg == NAC_PROG && timer_done && !prog_reset) begin
        ctrl_reg[`NAC_BIT_WR] <= 1'b0;
        ctrl_reg[`NAC_BIT_FREE] <= 1'b0;
      end
      if (state_reg == NAC_PROG && prog_reset) begin
        ctrl_reg[`NAC_BIT_ERR] <= 1'b1;
        ctrl_reg[`NAC_BIT_WR] <= 1'b0;
      end
      ctrl_reg[5] <= 1'b0;
    end
  end

  // Command to storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_cmd <= '0;
    end else begin
      nvm_cmd.space <= ctrl_reg[`NAC_BIT_CFG] ? 2'h2 : {1'b0, ctrl_reg[`NAC_BIT_PGM]};
      nvm_cmd.write <= state_reg == NAC_PROG && ctrl_reg[`NAC_BIT_WR]
                       && !prog_reset;
      nvm_cmd.erase <= state_reg == NAC_PROG && ctrl_reg[`NAC_BIT_FREE]
                       && !prog_reset;
      nvm_cmd.read <= state_reg == NAC_READ;
    end
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
    end else begin
      nac_irq_t ev;
      nac_irq_t clr;
      ev = 3'h0;
      clr = 3'h0;
      ev[`NAC_IRQ_WDONE] = state_reg == NAC_PROG && timer_done && !prog_reset;
      ev[`NAC_IRQ_RDONE] = state_reg == NAC_READ;
      ev[`NAC_IRQ_ERR] = state_reg == NAC_PROG && prog_reset;
      if (wr_acc && hit(paddr, `NAC_OFS_IRQ_STAT)) begin
        clr = pwdata[2:0];
      end
      stat_reg <= (stat_reg & ~clr) | ev;
      if (wr_acc && hit(paddr, `NAC_OFS_IRQ_MASK)) begin
        mask_reg <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  // APB slave, no wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hit(paddr, `NAC_OFS_CTRL)
                 || hit(paddr, `NAC_OFS_IRQ_STAT) || hit(paddr, `NAC_OFS_IRQ_MASK));
      if (rd_acc) begin
        if (hit(paddr, `NAC_OFS_CTRL)) begin
          prdata <= {24'h00_0000, ctrl_reg};
        end else if (hit(paddr, `NAC_OFS_IRQ_STAT)) begin
          prdata <= {29'h0000_0000, stat_reg};
        end else if (hit(paddr, `NAC_OFS_IRQ_MASK)) begin
          prdata <= {29'h0000_0000, mask_reg};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  wr_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ctrl_reg[`NAC_BIT_WR]) |-> $past(ctrl_reg[`NAC_BIT_WRITE_GATE]))
    else $error("write started without gate");
  rd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ctrl_reg[`NAC_BIT_RD]) |=> !ctrl_reg[`NAC_BIT_RD])
    else $error("read start not cleared");
  rd_flash_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ctrl_reg[`NAC_BIT_RD]) |-> !ctrl_reg[`NAC_BIT_PGM])
    else $error("read start set with flash");
  wr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == NAC_PROG && !timer_done && !prog_reset |=> ctrl_reg[`NAC_BIT_WR])
    else $error("write start dropped early");
  wr_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == NAC_PROG && timer_done && !prog_reset |=> !ctrl_reg[`NAC_BIT_WR]
    && !ctrl_reg[`NAC_BIT_FREE] && !ctrl_reg[`NAC_BIT_ERR] ##0 state_reg == NAC_IDLE)
    else $error("completion not handled");
  err_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == NAC_PROG && prog_reset |=> ctrl_reg[`NAC_BIT_ERR])
    else $error("write error not flagged");
  err_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == NAC_PROG && prog_reset |=> $stable(ctrl_reg[7:6]))
    else $error("select bits changed on error");
  erase_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    nvm_cmd.erase |-> $past(ctrl_reg[`NAC_BIT_FREE]))
    else $error("erase without enable");
  space_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(ctrl_reg[`NAC_BIT_CFG]) |-> nvm_cmd.space == 2'h2)
    else $error("space select wrong");
  write_cv: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == NAC_PROG && timer_done);
  read_cv: cover property (@(posedge clk) disable iff (!rst_n) state_reg == NAC_READ);
  err_cv: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == NAC_PROG && prog_reset);
endmodule
`default_nettype wire

// ==== verification/nac_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nac_regs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module nac_top_bench;
  import nac_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic prog_reset = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready, pslverr, irq, rerr;
  nac_cmd_s nvm_cmd;
  int errors = 0;
  int n_checks = 0;
  int rd_pulses = 0;
  logic write_seen = 1'b0;
  logic erase_seen = 1'b0;
  logic [1:0] space_seen = 2'h0;
  nac_top #(.PROG_CYCLES(16'h0020)) u_nac_top (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_reset(prog_reset), .nvm_cmd(nvm_cmd), .irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  // Watch the command outputs toward the storage array
  always @(posedge clk) begin
    if (nvm_cmd.read === 1'b1) rd_pulses++;
    if (nvm_cmd.write === 1'b1) begin
      write_seen = 1'b1;
      space_seen = nvm_cmd.space;
      erase_seen = erase_seen | nvm_cmd.erase;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_wr;
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, `NAC_OFS_CTRL, 32'h0000_0000);
      if (rdata[`NAC_BIT_WR] === 1'b0) break;
    end
  endtask
  // Gate first, then start in a later write
  task automatic prog(input logic [7:0] sel);
    write_seen = 1'b0; erase_seen = 1'b0;
    apb(1'b1, `NAC_OFS_CTRL, {24'h00_0000, sel | 8'h04});
    apb(1'b1, `NAC_OFS_CTRL, {24'h00_0000, sel | 8'h06});
  endtask
  task automatic t_reset;
    apb(1'b0, `NAC_OFS_CTRL, 32'h0000_0000);
    `CHK("ctrl reset", 32'h0000_0000, rdata)
    `CHK("ctrl err", 1'b0, rerr)
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0000_0000, rdata)
  endtask
  task automatic t_gate;
    write_seen = 1'b0;
    apb(1'b1, `NAC_OFS_CTRL, 32'h0000_0002);
    repeat (8) @(posedge clk);
    `CHK("no gate write", 1'b0, write_seen)
    apb(1'b0, `NAC_OFS_CTRL, 32'h0000_0000);
    `CHK("no gate ctrl", 32'h0000_0000, rdata)
  endtask
  task automatic t_write;
    apb(1'b1, `NAC_OFS_IRQ_MASK, 32'h0000_0000);
    prog(8'h00);
    apb(1'b1, `NAC_OFS_CTRL, 32'h0000_0004);
    apb(1'b0, `NAC_OFS_CTRL, 32'h0000_0000);
    `CHK("start kept", 1'b1, rdata[`NAC_BIT_WR])
    wait_wr();
    `CHK("done ctrl", 32'h0000_0004, rdata)
    `CHK("write seen", 1'b1, write_seen)
    apb(1'b0, `NAC_OFS_IRQ_STAT, 32'h0000_0000);
    `CHK("stat done", 32'h0000_0001, rdata)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, `NAC_OFS_IRQ_MASK, 32'h0000_0007);
    repeat (2) @(posedge clk);
    `CHK("irq up", 1'b1, irq)
    apb(1'b1, `NAC_OFS_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
  endtask
  task automatic t_space;
    logic [7:0] sel [3] = '{8'h00, 8'h80, 8'h40};
    logic [1:0] exp [3] = '{2'h0, 2'h1, 2'h2};
    for (int i = 0; i < 3; i++) begin
      prog(sel[i]);
      wait_wr();
      `CHK("space", exp[i], space_seen)
    end
  endtask
  task automatic t_erase;
    prog(8'h90);
    wait_wr();
    `CHK("erase seen", 1'b1, erase_seen)
    `CHK("erase cleared", 8'h84, rdata[7:0])
    prog(8'h80);
    wait_wr();
    `CHK("plain write", 1'b0, erase_seen)
  endtask
  task automatic t_read;
    apb(1'b1, `NAC_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, `NAC_OFS_IRQ_STAT, 32'h0000_0007);
    rd_pulses = 0;
    apb(1'b1, `NAC_OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    `CHK("read pulses", 1, rd_pulses)
    apb(1'b0, `NAC_OFS_CTRL, 32'h0000_0000);
    `CHK("read cleared", 32'h0000_0000, rdata)
    apb(1'b0, `NAC_OFS_IRQ_STAT, 32'h0000_0000);
    `CHK("stat read", 32'h0000_0002, rdata)
    apb(1'b1, `NAC_OFS_CTRL, 32'h0000_0081);
    repeat (3) @(posedge clk);
    `CHK("flash read", 1, rd_pulses)
    apb(1'b0, `NAC_OFS_CTRL, 32'h0000_0000);
    `CHK("flash ctrl", 32'h0000_0080, rdata)
  endtask
  task automatic t_error;
    prog(8'hc0);
    repeat (3) @(posedge clk);
    prog_reset <= 1'b1;
    @(posedge clk);
    prog_reset <= 1'b0;
    wait_wr();
    `CHK("err ctrl", 8'hcc, rdata[7:0])
    apb(1'b0, `NAC_OFS_IRQ_STAT, 32'h0000_0000);
    `CHK("stat err", 1'b1, rdata[`NAC_IRQ_ERR])
    `CHK("irq err", 1'b1, irq)
    apb(1'b1, `NAC_OFS_CTRL, 32'h0000_0000);
    apb(1'b0, `NAC_OFS_CTRL, 32'h0000_0000);
    `CHK("err cleared", 32'h0000_0000, rdata)
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_gate();
    t_write();
    t_space();
    t_erase();
    t_read();
    t_error();
    summarize();
  end
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
